//--- hdl/meter_cmd_pkg.sv
// Shared constants and types for the meter command and status engine
package meter_cmd_pkg;
   // Register byte addresses on the APB window
   localparam logic [7:0] ADDR_CMD     = 8'h00;
   localparam logic [7:0] ADDR_RESP    = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_FUNC    = 8'h0c;
   localparam logic [7:0] ADDR_MAKER   = 8'h10;
   localparam logic [7:0] ADDR_MODEL   = 8'h14;
   localparam logic [7:0] ADDR_SERIAL  = 8'h18;
   localparam logic [7:0] ADDR_VERSION = 8'h1c;
   // Event status register bit positions
   localparam int ESR_OPC = 0;
   localparam int ESR_QYE = 2;
   localparam int ESR_EXE = 4;
   localparam int ESR_CME = 5;
   localparam int ESR_PON = 7;
   // Status byte bit positions
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_MSS = 6;
   // Values after power-up and argument limits
   localparam logic [7:0]  ESR_RESET = 8'h80;
   localparam logic [7:0]  ESE_RESET = 8'h00;
   localparam logic [7:0]  SRE_RESET = 8'h00;
   localparam logic [7:0]  SRE_USED  = 8'hbf;
   localparam logic [15:0] ARG_MAX   = 16'h00ff;
   // Response kinds and fixed replies
   localparam logic [7:0] RESP_INT  = 8'h00;
   localparam logic [7:0] RESP_FUNC = 8'h01;
   localparam logic [7:0] RESP_IDN  = 8'h02;
   localparam logic [7:0] RESP_CHAR = 8'h03;
   localparam logic [7:0] OPC_REPLY = 8'h31;
   localparam logic [7:0] TST_REPLY = 8'h00;

   typedef enum logic [4:0] {
      OP_CLEAR_STATUS, OP_ESE_WRITE, OP_ESE_QUERY, OP_ESR_QUERY,
      OP_IDN_QUERY, OP_OPC, OP_OPC_QUERY, OP_RESET, OP_SRE_WRITE,
      OP_SRE_QUERY, OP_STB_QUERY, OP_TRIGGER, OP_TST_QUERY, OP_WAIT,
      OP_PRIMARY_SEL, OP_SECONDARY_SEL, PRIMARY_SELECTION_QUERY,
      SECONDARY_SELECTION_QUERY, TWO_LEAD_RESISTANCE,
      FOUR_LEAD_RESISTANCE, SECONDARY_READING_CLEAR
   } opcode_t;

   typedef enum logic [3:0] {
      FN_NONE, AC_CURRENT_SEL, AC_PLUS_DC_CURRENT_SEL, DC_CURRENT_SEL,
      CONTINUITY_SEL, DIODE_SEL, CYCLE_RATE_SEL, RESISTANCE_SEL,
      AC_VOLTAGE_SEL, AC_PLUS_DC_VOLTAGE_SEL, DC_VOLTAGE_SEL
   } func_t;

   typedef struct packed {
      logic [15:0] arg;
      logic [6:0]  pad_hi;
      logic        first;
      logic [2:0]  pad_lo;
      opcode_t     op;
   } cmd_t;

   typedef struct packed {
      logic [7:0] kind;
      logic [7:0] value;
   } resp_t;

   typedef struct packed {
      logic [7:0]  ese;
      logic [7:0]  sre;
      logic [7:0]  esr;
      logic        event_summary_bit;
      func_t       prim;
      func_t       sec;
      logic        four_wire;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        trigger;
   } eng_t;
endpackage

//--- hdl/response_slot.sv
// One-entry output queue holding the pending query answer
`timescale 1ns/1ps
`default_nettype none
module response_slot
   import meter_cmd_pkg::*;
(
   input  wire logic  clk_in,   // System clock
   input  wire logic  reset_in, // Synchronous reset
   input  wire logic  push_in,  // Store a new answer
   input  wire resp_t data_in,  // Answer to store
   input  wire logic  pop_in,   // Answer taken by host
   input  wire logic  clear_in, // Drop any answer
   output resp_t      data_out, // Held answer
   output logic       valid_out // Answer waiting
);
   typedef struct packed {
      resp_t data;
      logic  valid;
   } slot_t;
   slot_t cur;
   slot_t next_cur;

   // A push in the same cycle as a pop or clear wins, so no answer is lost
   always_comb begin
      next_cur = cur;
      if (pop_in || clear_in) begin
         next_cur.valid = 1'b0;
      end
      if (push_in) begin
         next_cur.valid = 1'b1;
         next_cur.data  = data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign data_out  = cur.data;
   assign valid_out = cur.valid;
endmodule // response_slot
`default_nettype wire

//--- hdl/status_byte.sv
// Status byte assembly with the master summary bit
`timescale 1ns/1ps
`default_nettype none
module status_byte
   import meter_cmd_pkg::*;
(
   input  wire logic       mav_in,  // Answer waiting
   input  wire logic       esb_in,  // Event summary
   input  wire logic [7:0] sre_in,  // Service request enable
   output logic [7:0]      stb_out  // Status byte as queried
);
   logic [7:0] raw;

   // Summary bits only; unused positions stay zero
   always_comb begin
      raw          = 8'h00;
      raw[STB_MAV] = mav_in;
      raw[STB_ESB] = esb_in;
      stb_out      = raw;
      stb_out[STB_MSS] = |(raw & sre_in & SRE_USED);
   end
endmodule // status_byte
`default_nettype wire

//--- hdl/meter_cmd_engine.sv
// Common command and function select engine behind an APB slave
//
// Functional notes
// - Clear status empties the event register and the event summary.
// - Clear status drops the waiting answer only when first in line.
// - Event enable write loads the 8-bit mask from its argument.
// - Enable write argument above 255 raises execution error, no load.
// - Event enable query returns the mask as last written.
// - Event status query returns the register, then clears it.
// - Identity query answers maker, model, serial and versions.
// - Operation complete command sets the operation complete bit.
// - Operation complete query queues an ASCII one.
// - Reset command repeats the power-up initialisation.
// - Service enable write loads its argument, discarding bit 6.
// - Service enable query always shows bit 6 as zero.
// - Status byte query returns bit 6 as the master summary bit.
// - Trigger command starts one measurement.
// - Selection queries return the active function's select code.
// - Secondary query with no secondary function is an execution error.
// - Lead count switches only while resistance is selected.
// - Secondary reading clear empties the secondary display.
// - AC plus DC functions are selectable on the primary only.
// - Enabled event rising sets event summary; read or clear drops it.
// - Master summary is set while any enabled status bit is set.
// - Understood but impossible commands set execution error bit 4.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module meter_cmd_engine
   import meter_cmd_pkg::*;
#(
   parameter logic [31:0] MAKER_CODE   = 32'h0000_0a51, // Arbitrary
   parameter logic [31:0] MODEL_CODE   = 32'h0000_0b62, // Arbitrary
   parameter logic [31:0] SERIAL_BCD   = 32'h0123_4567, // Arbitrary
   parameter logic [31:0] VERSION_CODE = 32'h0001_0001  // Arbitrary
)(
   input  wire logic        clk_in,      // 10 MHz system clock
   input  wire logic        reset_in,    // Synchronous power-up reset
   input  wire logic        psel_in,     // APB select
   input  wire logic        penable_in,  // APB access phase
   input  wire logic        pwrite_in,   // APB write
   input  wire logic [7:0]  paddr_in,    // APB byte address
   input  wire logic [31:0] pwdata_in,   // APB write data
   output logic [31:0]      prdata_out,  // APB read data
   output logic             pready_out,  // APB ready
   output logic             pslverr_out, // APB error
   output logic             trigger_out  // One-cycle measurement start
);
   eng_t       cur;
   eng_t       next_cur;
   cmd_t       cmd;
   resp_t      q_data;
   resp_t      push_data;
   logic       q_valid;
   logic       push;
   logic       pop;
   logic       clear_q;
   logic [7:0] stb;
   logic [7:0] ev;
   logic [7:0] esr_base;
   logic       esr_read;
   logic       wr_cmd;
   logic       rd_resp;
   logic       setup;
   logic       done;

   // Values the status and function registers take at power-up and on the reset command
   function automatic eng_t power_up(input eng_t keep);
      eng_t r;
      r           = keep;
      r.ese       = ESE_RESET;
      r.sre       = SRE_RESET;
      r.esr       = ESR_RESET;
      r.event_summary_bit       = 1'b0;
      r.prim      = DC_VOLTAGE_SEL;
      r.sec       = FN_NONE;
      r.four_wire = 1'b0;
      return r;
   endfunction

   // Only these functions have a secondary display form
   function automatic logic sec_capable(input func_t f);
      return f inside {AC_CURRENT_SEL, DC_CURRENT_SEL, CYCLE_RATE_SEL,
                       RESISTANCE_SEL, AC_VOLTAGE_SEL, DC_VOLTAGE_SEL};
   endfunction

   function automatic logic addr_ok(input logic [7:0] a, input logic w);
      if (w) begin
         return a == ADDR_CMD;
      end
      return a[7:5] == 3'h0 && a[1:0] == 2'h0;
   endfunction

   function automatic resp_t int_resp(input logic [7:0] v);
      return '{kind: RESP_INT, value: v};
   endfunction

   response_slot u_slot (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .push_in  (push),
      .data_in  (push_data),
      .pop_in   (pop),
      .clear_in (clear_q),
      .data_out (q_data),
      .valid_out(q_valid)
   );

   status_byte u_stb (
      .mav_in (q_valid),
      .esb_in (cur.event_summary_bit),
      .sre_in (cur.sre),
      .stb_out(stb)
   );

   // Bus phase decode; a transfer completes one cycle after its setup
   assign setup   = psel_in & ~penable_in;
   assign done    = psel_in & penable_in & cur.pready;
   assign cmd     = cmd_t'(pwdata_in);
   assign wr_cmd  = done & pwrite_in & (paddr_in == ADDR_CMD);
   assign rd_resp = done & ~pwrite_in & (paddr_in == ADDR_RESP);

   // Command execution, bus answer and event bookkeeping
   always_comb begin
      next_cur         = cur;
      ev               = 8'h00;
      push             = 1'b0;
      push_data        = '0;
      pop              = 1'b0;
      clear_q          = 1'b0;
      esr_read         = 1'b0;
      next_cur.trigger = 1'b0;
      next_cur.pready  = setup;
      next_cur.pslverr = setup & ~addr_ok(paddr_in, pwrite_in);
      if (setup) begin
         case (paddr_in)
            ADDR_RESP:    next_cur.prdata = q_valid ?
                                            {16'h0000, q_data} : 32'h0;
            ADDR_STATUS:  next_cur.prdata = {cur.esr, cur.sre & SRE_USED,
                                             cur.ese, stb};
            ADDR_FUNC:    next_cur.prdata = {22'h0, cur.sec != FN_NONE,
                                             cur.four_wire, cur.sec,
                                             cur.prim};
            ADDR_MAKER:   next_cur.prdata = MAKER_CODE;
            ADDR_MODEL:   next_cur.prdata = MODEL_CODE;
            ADDR_SERIAL:  next_cur.prdata = SERIAL_BCD;
            ADDR_VERSION: next_cur.prdata = VERSION_CODE;
            default:      next_cur.prdata = 32'h0;
         endcase
      end
      // Reading an empty answer slot is a query error
      if (rd_resp) begin
         pop         = q_valid;
         ev[ESR_QYE] = ~q_valid;
      end
      if (wr_cmd) begin
         case (cmd.op)
            OP_CLEAR_STATUS: begin
               esr_read = 1'b1;
               clear_q  = cmd.first;
            end
            OP_ESE_WRITE, OP_SRE_WRITE: begin
               if (cmd.arg > ARG_MAX) begin
                  ev[ESR_EXE] = 1'b1;
               end else if (cmd.op == OP_ESE_WRITE) begin
                  next_cur.ese = cmd.arg[7:0];
               end else begin
                  next_cur.sre = cmd.arg[7:0] & SRE_USED;
               end
            end
            OP_ESE_QUERY: begin
               push      = 1'b1;
               push_data = int_resp(cur.ese);
            end
            OP_ESR_QUERY: begin
               push      = 1'b1;
               push_data = int_resp(cur.esr);
               esr_read  = 1'b1;
            end
            OP_IDN_QUERY: begin
               // Fields are read from the four identity words
               push      = 1'b1;
               push_data = '{kind: RESP_IDN, value: 8'h04};
            end
            OP_OPC: ev[ESR_OPC] = 1'b1;
            OP_OPC_QUERY: begin
               push      = 1'b1;
               push_data = '{kind: RESP_CHAR, value: OPC_REPLY};
            end
            OP_RESET: begin
               next_cur = power_up(next_cur);
               clear_q  = 1'b1;
            end
            OP_SRE_QUERY: begin
               push      = 1'b1;
               push_data = int_resp(cur.sre & SRE_USED);
            end
            OP_STB_QUERY: begin
               push      = 1'b1;
               push_data = int_resp(stb);
            end
            OP_TRIGGER: next_cur.trigger = 1'b1;
            OP_TST_QUERY: begin
               push      = 1'b1;
               push_data = int_resp(TST_REPLY);
            end
            OP_WAIT: ;
            OP_PRIMARY_SEL: begin
               if (func_t'(cmd.arg[3:0]) inside {[AC_CURRENT_SEL :
                                                  DC_VOLTAGE_SEL]}) begin
                  next_cur.prim = func_t'(cmd.arg[3:0]);
               end else begin
                  ev[ESR_EXE] = 1'b1;
               end
            end
            OP_SECONDARY_SEL: begin
               if (sec_capable(func_t'(cmd.arg[3:0]))) begin
                  next_cur.sec = func_t'(cmd.arg[3:0]);
               end else begin
                  ev[ESR_EXE] = 1'b1;
               end
            end
            PRIMARY_SELECTION_QUERY: begin
               push      = 1'b1;
               push_data = '{kind: RESP_FUNC,
                             value: {4'h0, cur.prim}};
            end
            SECONDARY_SELECTION_QUERY: begin
               if (cur.sec == FN_NONE) begin
                  ev[ESR_EXE] = 1'b1;
               end else begin
                  push      = 1'b1;
                  push_data = '{kind: RESP_FUNC,
                                value: {4'h0, cur.sec}};
               end
            end
            TWO_LEAD_RESISTANCE, FOUR_LEAD_RESISTANCE: begin
               if (cur.prim == RESISTANCE_SEL) begin
                  next_cur.four_wire = cmd.op == FOUR_LEAD_RESISTANCE;
               end else begin
                  ev[ESR_EXE] = 1'b1;
               end
            end
            SECONDARY_READING_CLEAR: next_cur.sec = FN_NONE;
            default: ev[ESR_CME] = 1'b1;
         endcase
      end
      // New events are set after any clear, so a same-cycle event survives
      esr_base     = esr_read ? 8'h00 : next_cur.esr;
      next_cur.esr = esr_base | ev;
      if (|(ev & next_cur.ese & ~esr_base)) begin
         next_cur.event_summary_bit = 1'b1;
      end else if (esr_read) begin
         next_cur.event_summary_bit = 1'b0;
      end
   end

   // Single state register; reset leaves the bus idle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cur <= power_up('0);
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata_out  = cur.prdata;
   assign pready_out  = cur.pready;
   assign pslverr_out = cur.pslverr;
   assign trigger_out = cur.trigger;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   a_cls_clears_esr: assert property (
      wr_cmd && cmd.op == OP_CLEAR_STATUS |=> cur.esr == 8'h00 && !cur.event_summary_bit
   ) else $error("clear status left events");
   a_cls_keeps_mav: assert property (
      wr_cmd && cmd.op == OP_CLEAR_STATUS && !cmd.first && q_valid
      |=> q_valid
   ) else $error("clear status dropped answer");
   a_ese_loads: assert property (
      wr_cmd && cmd.op == OP_ESE_WRITE && cmd.arg <= ARG_MAX
      |=> cur.ese == $past(cmd.arg[7:0])
   ) else $error("event enable not loaded");
   a_range_reject: assert property (
      wr_cmd && cmd.op inside {OP_ESE_WRITE, OP_SRE_WRITE}
      && cmd.arg > ARG_MAX
      |=> cur.esr[ESR_EXE] && $stable(cur.ese) && $stable(cur.sre)
   ) else $error("bad argument accepted");
   a_esr_query: assert property (
      wr_cmd && cmd.op == OP_ESR_QUERY |=> cur.esr == 8'h00
      && q_data.value == $past(cur.esr) && q_valid
   ) else $error("event status query wrong");
   a_opc_event: assert property (
      wr_cmd && cmd.op == OP_OPC |=> cur.esr[ESR_OPC]
   ) else $error("operation complete not set");
   a_opc_reply: assert property (
      wr_cmd && cmd.op == OP_OPC_QUERY
      |=> q_valid && q_data.value == OPC_REPLY
   ) else $error("operation complete reply wrong");
   a_sre_no_bit6: assert property (
      wr_cmd && cmd.op == OP_SRE_WRITE && cmd.arg <= ARG_MAX
      |=> !cur.sre[STB_MSS] && cur.sre[5:0] == $past(cmd.arg[5:0])
   ) else $error("service enable bit 6 kept");
   a_trigger_once: assert property (
      wr_cmd && cmd.op == OP_TRIGGER |=> trigger_out ##1 !trigger_out
   ) else $error("trigger not one pulse");
   a_sec_query_err: assert property (
      wr_cmd && cmd.op == SECONDARY_SELECTION_QUERY && cur.sec == FN_NONE
      |=> cur.esr[ESR_EXE] && $stable(q_valid)
   ) else $error("empty secondary query passed");
   a_lead_gate: assert property (
      wr_cmd && cmd.op inside {TWO_LEAD_RESISTANCE, FOUR_LEAD_RESISTANCE}
      && cur.prim != RESISTANCE_SEL |=> $stable(cur.four_wire)
   ) else $error("lead count changed off resistance");
   // Outcome checks; the summary check needs a masked bit rising from 0
   a_esb_on_rise: assert property (
      wr_cmd && cmd.op == OP_OPC && cur.ese[ESR_OPC] && !cur.esr[ESR_OPC]
      |=> cur.event_summary_bit
   ) else $error("event summary not raised");
   a_sre_query_bit6: assert property (
      wr_cmd && cmd.op == OP_SRE_QUERY |=> q_valid && !q_data.value[STB_MSS]
   ) else $error("service enable query shows bit 6");
   a_reset_cmd: assert property (
      wr_cmd && cmd.op == OP_RESET |=> cur.esr == ESR_RESET
      && cur.ese == ESE_RESET && cur.sre == SRE_RESET
      && cur.prim == DC_VOLTAGE_SEL && cur.sec == FN_NONE && !q_valid
   ) else $error("reset command left state");
   a_tst_zero: assert property (
      wr_cmd && cmd.op == OP_TST_QUERY
      |=> q_valid && q_data.value == TST_REPLY
   ) else $error("self test answer not zero");
   a_ready_follows: assert property (
      setup |=> pready_out ##1 !pready_out
   ) else $error("ready not one cycle after setup");

   c_esr_query: cover property (wr_cmd && cmd.op == OP_ESR_QUERY);
   c_esb_raised: cover property (!cur.event_summary_bit ##1 cur.event_summary_bit);
   c_range_error: cover property (wr_cmd && cmd.arg > ARG_MAX);
   c_resp_read: cover property (rd_resp && q_valid);
endmodule // meter_cmd_engine
`default_nettype wire

//--- tb/apb_host_model.sv
// Host-side APB master model issuing register transfers
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
   input  wire logic        clk_in,      // System clock
   input  wire logic [31:0] prdata_in,   // Read data
   input  wire logic        pready_in,   // Ready
   input  wire logic        pslverr_in,  // Error
   output logic             psel_out    = 1'b0,  // Select
   output logic             penable_out = 1'b0,  // Access phase
   output logic             pwrite_out  = 1'b0,  // Direction
   output logic [7:0]       paddr_out   = 8'h00, // Byte address
   output logic [31:0]      pwdata_out  = 32'h0  // Write data
);
   // Bus idles from time zero; only the task below drives it afterwards
   // One transfer, held until ready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do @(posedge clk_in); while (pready_in !== 1'b1);
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      pwdata_out <= ~d; // Stale data would hide a late sampling slave
   endtask
endmodule // apb_host_model
`default_nettype wire

//--- tb/meter_common_command_status_engine_tb.sv
// Self-checking bench for the meter command engine
`timescale 1ns/1ps
`default_nettype none
module meter_common_command_status_engine_tb;
   import meter_cmd_pkg::*;
   localparam logic [31:0] MAKER = 32'h0000_1d2e; // Arbitrary
   localparam logic [31:0] MODEL = 32'h0000_2e3f; // Arbitrary
   localparam logic [31:0] SERNO = 32'h0765_4321; // Arbitrary
   localparam logic [31:0] VERS  = 32'h0002_0003; // Arbitrary
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, trigger;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        e;
   int          bad_count = 0;
   int          compares = 0;
   int          trig_seen = 0;
   int          ese, sre, esr, event_summary_bit, message_waiting_bit, rk, rv, prim, sec, fw, trig_exp;
   logic [31:0] ids [4];

   always #50 clk_in = ~clk_in;

   meter_cmd_engine #(.MAKER_CODE(MAKER), .MODEL_CODE(MODEL),
      .SERIAL_BCD(SERNO), .VERSION_CODE(VERS)) meter_cmd_engine_inst (
      .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .trigger_out(trigger));

   apb_host_model apb_host_model_inst (
      .clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
      .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

   // Count measurement start pulses as they stand
   always @(posedge clk_in) if (trigger === 1'b1) trig_seen <= trig_seen + 1;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reference model, power-up state
   function void init_model;
      ese = 0;
      sre = 0;
      esr = 8'h80;
      event_summary_bit = 0;
      message_waiting_bit = 0;
      prim = 10;
      sec = 0;
      fw = 0;
   endfunction
   // Event summary follows only a rising enabled event
   function void set_esr(input int b);
      if (((esr | b) & ~esr & ese) != 0) event_summary_bit = 1;
      esr = esr | b;
   endfunction
   function int stb_val;
      int s;
      s = (message_waiting_bit << 4) | (event_summary_bit << 5);
      if ((s & sre & 8'hbf) != 0) s = s | 64;
      return s;
   endfunction
   function void push(input int k, input int x);
      rk = k;
      rv = x;
      message_waiting_bit = 1;
   endfunction

   // Issue one command and advance the model
   task do_cmd(input opcode_t op, input int arg, input logic first);
      apb_host_model_inst.xfer(1'b1, ADDR_CMD,
         {arg[15:0], 7'h00, first, 3'h0, op}, q, e);
      check({31'h0, e}, 32'h0);
      case (op)
         OP_CLEAR_STATUS: begin
            esr = 0;
            event_summary_bit = 0;
            message_waiting_bit = first ? 0 : message_waiting_bit;
         end
         OP_ESE_WRITE: if (arg > 255) set_esr(16); else ese = arg;
         OP_ESE_QUERY: push(0, ese);
         OP_ESR_QUERY: begin
            push(0, esr);
            esr = 0;
            event_summary_bit = 0;
         end
         OP_IDN_QUERY: push(2, 4);
         OP_OPC: set_esr(1);
         OP_OPC_QUERY: push(3, 8'h31);
         OP_RESET: init_model();
         OP_SRE_WRITE: if (arg > 255) set_esr(16); else sre = arg & 8'hbf;
         OP_SRE_QUERY: push(0, sre);
         OP_STB_QUERY: push(0, stb_val());
         OP_TRIGGER: trig_exp++;
         OP_TST_QUERY: push(0, 0);
         OP_PRIMARY_SEL: if (arg inside {[1:10]}) prim = arg;
            else set_esr(16);
         OP_SECONDARY_SEL: if (arg inside {1, 3, 6, 7, 8, 10}) sec = arg;
            else set_esr(16);
         PRIMARY_SELECTION_QUERY: push(1, prim);
         SECONDARY_SELECTION_QUERY: if (sec == 0) set_esr(16);
            else push(1, sec);
         TWO_LEAD_RESISTANCE, FOUR_LEAD_RESISTANCE: if (prim == 7)
            fw = (op == FOUR_LEAD_RESISTANCE); else set_esr(16);
         SECONDARY_READING_CLEAR: sec = 0;
         default: ;
      endcase
   endtask

   task chk_status;
      int s;
      apb_host_model_inst.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
      s = stb_val();
      check(q, {esr[7:0], sre[7:0], ese[7:0], s[7:0]});
   endtask
   // Reading the answer pops it; an empty read is a query error
   task chk_resp;
      apb_host_model_inst.xfer(1'b0, ADDR_RESP, 32'h0, q, e);
      check(q, message_waiting_bit ? {16'h0, rk[7:0], rv[7:0]} : 32'h0);
      if (message_waiting_bit == 0) set_esr(4);
      message_waiting_bit = 0;
   endtask
   task chk_func;
      apb_host_model_inst.xfer(1'b0, ADDR_FUNC, 32'h0, q, e);
      check(q, {22'h0, sec != 0, fw[0], sec[3:0], prim[3:0]});
   endtask

   // Watchdog sized well above the expected run
   initial begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      give_verdict();
   end

   initial begin
      ids = '{MAKER, MODEL, SERNO, VERS};
      void'($urandom(32'h6b18));
      init_model();
      trig_exp = 0;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      chk_status();
      chk_func();
      $display("test reset done");
      // Random legal masks, bit 6 of the service mask forced high
      for (int i = 0; i < 4; i++) begin
         do_cmd(OP_ESE_WRITE, $urandom_range(255), 1'b0);
         do_cmd(OP_ESE_QUERY, 0, 1'b0);
         chk_resp();
         do_cmd(OP_SRE_WRITE, $urandom_range(255) | 64, 1'b0);
         do_cmd(OP_SRE_QUERY, 0, 1'b0);
         chk_resp();
      end
      do_cmd(OP_ESE_WRITE, 255, 1'b0);
      chk_status();
      $display("test masks done");
      do_cmd(OP_ESR_QUERY, 0, 1'b0);
      chk_resp();
      do_cmd(OP_ESE_WRITE, 8'h11, 1'b0);
      do_cmd(OP_SRE_WRITE, 8'h20, 1'b0);
      chk_status();
      do_cmd(OP_ESE_WRITE, 256 + $urandom_range(1000), 1'b0);
      chk_status();
      do_cmd(OP_STB_QUERY, 0, 1'b0);
      chk_resp();
      do_cmd(OP_SRE_WRITE, 16'hffff, 1'b0);
      do_cmd(OP_ESR_QUERY, 0, 1'b0);
      chk_resp();
      chk_status();
      $display("test events done");
      do_cmd(OP_OPC, 0, 1'b0);
      chk_status();
      do_cmd(OP_OPC_QUERY, 0, 1'b0);
      do_cmd(OP_CLEAR_STATUS, 0, 1'b0);
      chk_status();
      chk_resp();
      do_cmd(OP_TST_QUERY, 0, 1'b0);
      do_cmd(OP_CLEAR_STATUS, 0, 1'b1);
      chk_status();
      chk_resp();
      chk_status();
      do_cmd(OP_IDN_QUERY, 0, 1'b0);
      chk_resp();
      for (int i = 0; i < 4; i++) begin
         apb_host_model_inst.xfer(1'b0, ADDR_MAKER + 8'(4 * i), 32'h0, q, e);
         check(q, ids[i]);
      end
      do_cmd(OP_TST_QUERY, 0, 1'b0);
      chk_resp();
      do_cmd(OP_WAIT, 0, 1'b0);
      chk_status();
      do_cmd(OP_TRIGGER, 0, 1'b0);
      do_cmd(OP_TRIGGER, 0, 1'b0);
      $display("test common done");
      for (int f = 1; f <= 10; f++) begin
         do_cmd(OP_PRIMARY_SEL, f, 1'b0);
         do_cmd(PRIMARY_SELECTION_QUERY, 0, 1'b0);
         chk_resp();
      end
      for (int f = 0; f <= 10; f++) begin
         do_cmd(OP_SECONDARY_SEL, f, 1'b0);
         chk_func();
      end
      chk_status();
      do_cmd(SECONDARY_SELECTION_QUERY, 0, 1'b0);
      chk_resp();
      do_cmd(SECONDARY_READING_CLEAR, 0, 1'b0);
      do_cmd(OP_ESR_QUERY, 0, 1'b0);
      chk_resp();
      do_cmd(SECONDARY_SELECTION_QUERY, 0, 1'b0);
      chk_status();
      chk_func();
      do_cmd(FOUR_LEAD_RESISTANCE, 0, 1'b0);
      chk_func();
      do_cmd(OP_PRIMARY_SEL, 7, 1'b0);
      do_cmd(FOUR_LEAD_RESISTANCE, 0, 1'b0);
      chk_func();
      do_cmd(TWO_LEAD_RESISTANCE, 0, 1'b0);
      chk_func();
      do_cmd(FOUR_LEAD_RESISTANCE, 0, 1'b0);
      $display("test functions done");
      apb_host_model_inst.xfer(1'b0, 8'h24, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      do_cmd(OP_RESET, 0, 1'b0);
      chk_status();
      chk_func();
      check(trig_seen, trig_exp);
      $display("test reset command done");
      give_verdict();
   end
endmodule // meter_common_command_status_engine_tb
`default_nettype wire
